/* File: mon_pkg.sv */
// package: constants and carrier types for the monitor status flags
package mon_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] MON_ADDR_STAT_ONE = 8'h41;
    localparam logic [7:0] MON_ADDR_STAT_TWO = 8'h42;
    localparam logic [7:0] MON_STAT_RESET = 8'h00;
    localparam logic [7:0] MON_UNMAPPED_DATA = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MON_S1_VOLT_LSB = 0;
    localparam int MON_S1_TEMP_LSB = 4;
    localparam int MON_S1_SUMMARY = 7;
    localparam int MON_S2_CODE = 0;
    localparam int MON_S2_OVT = 1;
    localparam int MON_S2_FAN_LSB = 2;
    localparam int MON_S2_FAN4 = 5;
    localparam int MON_S2_DIODE_LSB = 6;
    localparam int MON_TWELVE_IDX = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MON_CLK_PERIOD_NS = 25;
    localparam int MON_CODE_WINDOW_NS = 11000;
    localparam int MON_CODE_WINDOW_CYC =
        (MON_CODE_WINDOW_NS + MON_CLK_PERIOD_NS - 1) / MON_CLK_PERIOD_NS;
    localparam int MON_CODE_CNT_W = 9;
    localparam int MON_TICK_CNT_W = 16;
    localparam int MON_ACC_W = 9;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0][7:0] volt;
        logic [4:0][7:0] volt_lo;
        logic [4:0][7:0] volt_hi;
        logic [2:0][7:0] temp;
        logic [2:0][7:0] temp_lo;
        logic [2:0][7:0] temp_hi;
        logic [3:0][15:0] fan_tachometer;
        logic [3:0][15:0] fan_tachometer_min;
    } mon_meas_t;

    typedef struct packed {
        logic [6:0] stat1;
        logic [7:0] stat2;
        logic [5:0] code_snap;
        logic code_snap_ok;
        logic [MON_CODE_CNT_W-1:0] code_cnt;
        logic [MON_TICK_CNT_W-1:0] tick_cnt;
        logic [MON_ACC_W-1:0] alert_acc;
        logic [7:0] rd_data;
        logic rd_valid;
        logic alert_n;
    } mon_state_t;

endpackage

/* File: mon_limit_cmp.sv */
// limit comparator: strict high test, inclusive low test
`timescale 1ns/1ps
`default_nettype none
module mon_limit_cmp #(
    parameter int W = 8,
    parameter bit SIGNED_CMP = 1'b0,
    parameter bit USE_LOW = 1'b1
) (
    // operands
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] lo,
    input wire logic [W-1:0] hi,
    // result
    output logic viol
);
    logic gt_hi;
    logic le_lo;

    generate
        if (SIGNED_CMP) begin : g_signed
            assign gt_hi = $signed(value) > $signed(hi); // R16
            assign le_lo = $signed(value) <= $signed(lo); // R17
        end else begin : g_unsigned
            assign gt_hi = value > hi; // R16 R18
            assign le_lo = value <= lo; // R17
        end
    endgenerate

    // fan periods only have an upper bound, so the low test is dropped
    assign viol = gt_hi | (USE_LOW & le_lo);
endmodule
`default_nettype wire

/* File: mon_status_flags.sv */
// status flag registers of the hardware monitor with read-to-clear
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: status one bits 0-3 flag voltage limits
// R2: status one bits 4-6 flag temperature limits
// R3: flags stick; read clears once cause gone
// R4: status one bit 7 ORs status two
// R5: host may poll only the summary bit
// R6: status two bit 0 flags twelve volt limits
// R7: select one: bit 0 flags code change
// R8: code change flag drives the bus alert
// R9: overtemp flag clears after hysteresis recovery
// R10: status two bits 2-4 flag slow fans
// R11: fan flags held clear while drive off
// R12: bit 5 fan four, gated by drive three
// R13: timer mode: bit 5 flags alert time limit
// R14: bits 6-7 flag diode open or short
// R15: both registers reset zero, read only
// R16: high violation only when strictly above limit
// R17: low violation when at or below limit
// R18: fan slow when period exceeds minimum limit
// R19: select one gives pin code role
// R20: clearing read returns values before clear
module mon_status_flags
    import mon_pkg::*;
#(
    parameter int ALERT_TICK_CYCLES = 40
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // measurements and limits
    input wire mon_pkg::mon_meas_t meas,
    input wire logic thermal_alert_pin_exceed,
    input wire logic thermal_alert_pin_recovered,
    input wire logic [1:0] diode_fault,
    input wire logic [2:0] fan_drive_on,
    // pin roles and codes
    input wire logic shared_pin_role_select,
    input wire logic [5:0] processor_voltage_code,
    input wire logic timer_pin_mode,
    input wire logic thermal_alert_pin,
    input wire logic [7:0] alert_time_limit,
    // register read port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_ff,
    output logic rd_valid_ff,
    // alert
    output logic bus_alert_n_ff
);
    import mon_pkg::*;

    generate
        if (ALERT_TICK_CYCLES < 1 ||
            ALERT_TICK_CYCLES >= (1 << MON_TICK_CNT_W)) begin : g_chk
            $error("ALERT_TICK_CYCLES out of range");
        end
    endgenerate

    localparam logic [MON_TICK_CNT_W-1:0] TICK_LAST =
        MON_TICK_CNT_W'(ALERT_TICK_CYCLES - 1);
    localparam logic [MON_CODE_CNT_W-1:0] CODE_LAST =
        MON_CODE_CNT_W'(MON_CODE_WINDOW_CYC - 1);
    localparam logic [MON_ACC_W-1:0] ACC_MAX = '1;

    mon_state_t st_ff;
    mon_state_t nxt_st;
    logic [4:0] volt_viol;
    logic [2:0] temp_viol;
    logic [3:0] fan_viol;

    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_volt
            mon_limit_cmp #(.W(8), .SIGNED_CMP(1'b0), .USE_LOW(1'b1))
            u_cmp (
                .value(meas.volt[gi]),
                .lo(meas.volt_lo[gi]),
                .hi(meas.volt_hi[gi]),
                .viol(volt_viol[gi])
            );
        end
        for (gi = 0; gi < 3; gi++) begin : g_temp
            mon_limit_cmp #(.W(8), .SIGNED_CMP(1'b1), .USE_LOW(1'b1))
            u_cmp (
                .value(meas.temp[gi]),
                .lo(meas.temp_lo[gi]),
                .hi(meas.temp_hi[gi]),
                .viol(temp_viol[gi])
            );
        end
        for (gi = 0; gi < 4; gi++) begin : g_fan
            mon_limit_cmp #(.W(16), .SIGNED_CMP(1'b0), .USE_LOW(1'b0))
            u_cmp (
                .value(meas.fan_tachometer[gi]),
                .lo(16'h0000),
                .hi(meas.fan_tachometer_min[gi]),
                .viol(fan_viol[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic rd_one;
    logic rd_two;
    logic code_event;
    logic timer_over;
    logic [6:0] set1;
    logic [7:0] set2;
    logic [7:0] keep2;

    always_comb begin
        nxt_st = st_ff;
        rd_one = 1'b0;
        rd_two = 1'b0;
        if (rd_en && rd_addr == MON_ADDR_STAT_ONE) begin
            rd_one = 1'b1;
        end else if (rd_en && rd_addr == MON_ADDR_STAT_TWO) begin
            rd_two = 1'b1;
        end

        // code sampling window; the first window only arms the snapshot
        // a code that flips and returns inside one window goes unseen
        code_event = 1'b0;
        if (st_ff.code_cnt == CODE_LAST) begin
            nxt_st.code_cnt = '0;
            nxt_st.code_snap = processor_voltage_code;
            nxt_st.code_snap_ok = 1'b1;
            code_event = shared_pin_role_select && st_ff.code_snap_ok &&
                (processor_voltage_code != st_ff.code_snap); // R7 R19
        end else begin
            nxt_st.code_cnt = st_ff.code_cnt + 1'b1;
        end

        // alert assertion time, in ticks, saturating
        // tick length is a parameter: the true unit is not fixed here
        if (timer_pin_mode && thermal_alert_pin) begin
            if (st_ff.tick_cnt == TICK_LAST) begin
                nxt_st.tick_cnt = '0;
                if (st_ff.alert_acc != ACC_MAX) begin
                    nxt_st.alert_acc = st_ff.alert_acc + 1'b1;
                end
            end else begin
                nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
            end
        end
        timer_over = st_ff.alert_acc > {1'b0, alert_time_limit}; // R13
        // reading status two restarts the accumulation
        if (rd_two) begin
            nxt_st.tick_cnt = '0;
            nxt_st.alert_acc = '0;
        end

        // a present cause re-sets the flag even in a clearing read
        set1[3:0] = volt_viol[3:0]; // R1 R16 R17
        set1[6:4] = temp_viol; // R2
        nxt_st.stat1 = set1 | (st_ff.stat1 & ~{7{rd_one}}); // R3 R20

        if (shared_pin_role_select) begin
            set2[MON_S2_CODE] = code_event; // R7
        end else begin
            set2[MON_S2_CODE] = volt_viol[MON_TWELVE_IDX]; // R6
        end
        set2[MON_S2_OVT] = thermal_alert_pin_exceed; // R9
        set2[4:2] = fan_viol[2:0] & fan_drive_on; // R10 R11 R18
        if (timer_pin_mode) begin
            set2[MON_S2_FAN4] = timer_over; // R13
        end else begin
            set2[MON_S2_FAN4] = fan_viol[3] & fan_drive_on[2]; // R12
        end
        set2[7:6] = diode_fault; // R14

        keep2 = ~{8{rd_two}};
        // overtemp survives a read until below limit minus hysteresis
        keep2[MON_S2_OVT] = ~rd_two | ~thermal_alert_pin_recovered; // R9
        nxt_st.stat2 = set2 | (st_ff.stat2 & keep2); // R3 R20

        // read data captured from the flags before this clear
        nxt_st.rd_valid = rd_en;
        if (rd_one) begin
            nxt_st.rd_data = {|st_ff.stat2, st_ff.stat1}; // R4 R5 R20
        end else if (rd_two) begin
            nxt_st.rd_data = st_ff.stat2; // R20
        end else begin
            nxt_st.rd_data = MON_UNMAPPED_DATA;
        end

        nxt_st.alert_n = ~(|nxt_st.stat1 | |nxt_st.stat2); // R8
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
            st_ff.stat1 <= MON_STAT_RESET[6:0]; // R15
            st_ff.stat2 <= MON_STAT_RESET; // R15
            st_ff.rd_data <= MON_UNMAPPED_DATA;
            st_ff.alert_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data_ff = st_ff.rd_data;
    assign rd_valid_ff = st_ff.rd_valid;
    assign bus_alert_n_ff = st_ff.alert_n;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    volt_flag_set_a: assert property ( // R1
        volt_viol[0] |=> st_ff.stat1[0])
        else $error("voltage violation did not set its flag");
    temp_flag_set_a: assert property ( // R2
        temp_viol[1] |=> st_ff.stat1[5])
        else $error("local temperature violation not flagged");
    clear_when_gone_a: assert property ( // R3
        (rd_one && set1 == 7'h00) |=> st_ff.stat1 == 7'h00)
        else $error("status one not cleared by read");
    stick_no_read_a: assert property ( // R3
        (st_ff.stat1[2] && !rd_one) |=> st_ff.stat1[2])
        else $error("flag dropped without a read");
    summary_bit_a: assert property ( // R4
        rd_one |=> rd_data_ff[7] == $past(|st_ff.stat2))
        else $error("summary bit does not match status two");
    twelve_flag_a: assert property ( // R6
        (!shared_pin_role_select && volt_viol[4]) |=> st_ff.stat2[0])
        else $error("twelve volt violation not flagged");
    code_flag_a: assert property ( // R7
        code_event |=> st_ff.stat2[0])
        else $error("code change not flagged");
    alert_out_a: assert property ( // R8
        st_ff.stat2[0] |-> !bus_alert_n_ff)
        else $error("alert not asserted with code change flag");
    ovt_hold_a: assert property ( // R9
        (st_ff.stat2[1] && !thermal_alert_pin_recovered) |=> st_ff.stat2[1])
        else $error("overtemp flag cleared before recovery");
    fan_gate_a: assert property ( // R11
        (rd_two && !fan_drive_on[0]) |=> !st_ff.stat2[2])
        else $error("fan one flag set with drive off");
    fan_slow_a: assert property ( // R10
        (fan_viol[1] && fan_drive_on[1]) |=> st_ff.stat2[3])
        else $error("slow fan two not flagged");
    timer_flag_a: assert property ( // R13
        (timer_pin_mode && timer_over) |=> st_ff.stat2[5])
        else $error("alert timer limit not flagged");
    diode_flag_a: assert property ( // R14
        diode_fault[1] |=> st_ff.stat2[7])
        else $error("diode two fault not flagged");
    high_strict_a: assert property ( // R16
        (meas.volt[3] == meas.volt_hi[3] &&
         meas.volt[3] > meas.volt_lo[3]) |-> !volt_viol[3])
        else $error("equal to high limit counted as violation");
    low_equal_a: assert property ( // R17
        (meas.volt[1] == meas.volt_lo[1]) |-> volt_viol[1])
        else $error("equal to low limit not counted");
    read_before_a: assert property ( // R20
        rd_two |=> rd_data_ff == $past(st_ff.stat2) && rd_valid_ff)
        else $error("read data not captured before clear");

    // remaining channels and gates
    volt_five_a: assert property ( // R1
        volt_viol[3] |=> st_ff.stat1[3])
        else $error("five volt violation not flagged");
    remote_one_a: assert property ( // R2
        temp_viol[0] |=> st_ff.stat1[4])
        else $error("remote one temperature not flagged");
    remote_two_a: assert property ( // R2
        temp_viol[2] |=> st_ff.stat1[6])
        else $error("remote two temperature not flagged");
    code_alert_a: assert property ( // R8
        code_event |=> !bus_alert_n_ff)
        else $error("code change did not assert the alert");
    ovt_set_a: assert property ( // R9
        thermal_alert_pin_exceed |=> st_ff.stat2[1])
        else $error("overtemp not flagged");
    fan_three_a: assert property ( // R10
        (fan_viol[2] && fan_drive_on[2]) |=> st_ff.stat2[4])
        else $error("slow fan three not flagged");
    fan_four_gate_a: assert property ( // R12
        (!timer_pin_mode && rd_two && !fan_drive_on[2]) |=> !st_ff.stat2[5])
        else $error("fan four flag set with drive three off");
    diode_one_a: assert property ( // R14
        diode_fault[0] |=> st_ff.stat2[6])
        else $error("diode one fault not flagged");
    fan_equal_a: assert property ( // R18
        (meas.fan_tachometer[0] == meas.fan_tachometer_min[0]) |-> !fan_viol[0])
        else $error("period equal to minimum counted as slow");

    read_clear_c: cover property (rd_one && st_ff.stat1 != 7'h00);
    code_change_c: cover property (code_event);
    timer_over_c: cover property (timer_pin_mode && timer_over);
    ovt_hold_c: cover property (rd_two && st_ff.stat2[1] && !thermal_alert_pin_recovered);
    twelve_volt_c: cover property (!shared_pin_role_select && volt_viol[4]);
endmodule
`default_nettype wire

/* File: mon_host_model.sv */
// host software model: reads status registers one byte at a time
`timescale 1ns/1ps
`default_nettype none
module mon_host_model (
    // clock
    input wire logic sys_clk,
    // read request
    output logic rd_en,
    output logic [7:0] rd_addr,
    // read answer
    input wire logic [7:0] rd_data_ff,
    input wire logic rd_valid_ff
);
    initial begin
        rd_en = 1'b0;
        rd_addr = 8'h00;
    end

    // request held over the taking edge, answer taken 1 ns after that same edge
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        #1;
        rd_en = 1'b1;
        rd_addr = addr;
        @(posedge sys_clk);
        #1;
        rd_en = 1'b0;
        // released address must not look like a valid one
        rd_addr = ~addr;
        data = (rd_valid_ff === 1'b1) ? rd_data_ff : 8'hXX;
    endtask

    // cheap poll of the summary bit only
    task automatic poll_summary(output logic flag);
        logic [7:0] d;
        read_reg(8'h41, d);
        flag = d[7];
    endtask
endmodule
`default_nettype wire

/* File: mon_status_flags_tb.sv */
// self-checking bench for the monitor status flag registers
`timescale 1ns/1ps
`default_nettype none
module mon_status_flags_tb;
    import mon_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    mon_meas_t meas;
    logic thermal_alert_pin_exceed, thermal_alert_pin_recovered, shared_pin_role_select;
    logic timer_pin_mode, thermal_alert_pin, rd_en, rd_valid_ff;
    logic bus_alert_n_ff, sum;
    logic [1:0] diode_fault;
    logic [2:0] fan_drive_on;
    logic [5:0] processor_voltage_code;
    logic [7:0] alert_time_limit, rd_addr, rd_data_ff;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;

    mon_status_flags #(.ALERT_TICK_CYCLES(2)) u_mon_status_flags (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .meas(meas),
        .thermal_alert_pin_exceed(thermal_alert_pin_exceed), .thermal_alert_pin_recovered(thermal_alert_pin_recovered),
        .diode_fault(diode_fault), .fan_drive_on(fan_drive_on),
        .shared_pin_role_select(shared_pin_role_select),
        .processor_voltage_code(processor_voltage_code),
        .timer_pin_mode(timer_pin_mode),
        .thermal_alert_pin(thermal_alert_pin),
        .alert_time_limit(alert_time_limit), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data_ff(rd_data_ff),
        .rd_valid_ff(rd_valid_ff), .bus_alert_n_ff(bus_alert_n_ff));

    mon_host_model u_mon_host_model (
        .sys_clk(sys_clk), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff));

    always #12.5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard, well above the under one thousand cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("unexpected timeout: expected end, seen cycle %0d", cycles);
            report_and_stop();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        u_mon_host_model.read_reg(addr, got);
        chk($sformatf("reg %h", addr), exp, got);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk(MON_ADDR_STAT_ONE, 8'h00);
        rd_chk(MON_ADDR_STAT_TWO, 8'h00);
        rd_chk(8'h40, 8'h00);
        $display("test reset done");
    endtask

    // cause present at a read keeps the flag; equal to high is no fault
    task automatic t_volt();
        for (int i = 0; i < 4; i++) begin
            meas.volt[i] = meas.volt_hi[i] + 8'h01;
            tick(2);
            rd_chk(MON_ADDR_STAT_ONE, 8'h01 << i);
            rd_chk(MON_ADDR_STAT_ONE, 8'h01 << i);
            meas.volt[i] = meas.volt_hi[i];
            rd_chk(MON_ADDR_STAT_ONE, 8'h01 << i);
            rd_chk(MON_ADDR_STAT_ONE, 8'h00);
        end
        $display("test volt done");
    endtask

    task automatic t_temp();
        for (int j = 0; j < 3; j++) begin
            meas.temp[j] = meas.temp_lo[j];
            tick(2);
            rd_chk(MON_ADDR_STAT_ONE, 8'h10 << j);
            meas.temp[j] = meas.temp_lo[j] + 8'h01;
            rd_chk(MON_ADDR_STAT_ONE, 8'h10 << j);
            rd_chk(MON_ADDR_STAT_ONE, 8'h00);
        end
        $display("test temp done");
    endtask

    task automatic t_diode();
        for (int d = 0; d < 2; d++) begin
            diode_fault = 2'b01 << d;
            tick(2);
            u_mon_host_model.poll_summary(sum);
            chk("summary", 8'h01, {7'h00, sum});
            diode_fault = 2'b00;
            rd_chk(MON_ADDR_STAT_TWO, 8'h40 << d);
            rd_chk(MON_ADDR_STAT_TWO, 8'h00);
            rd_chk(MON_ADDR_STAT_ONE, 8'h00);
        end
        $display("test diode done");
    endtask

    // fan four shares drive three
    task automatic t_fan();
        for (int k = 0; k < 4; k++) begin
            fan_drive_on = 3'b111;
            meas.fan_tachometer[k] = meas.fan_tachometer_min[k];
            tick(2);
            rd_chk(MON_ADDR_STAT_TWO, 8'h00);
            fan_drive_on[(k < 3) ? k : 2] = 1'b0;
            meas.fan_tachometer[k] = meas.fan_tachometer_min[k] + 16'h0001;
            tick(2);
            rd_chk(MON_ADDR_STAT_TWO, 8'h00);
            fan_drive_on = 3'b111;
            tick(2);
            meas.fan_tachometer[k] = 16'h0800;
            rd_chk(MON_ADDR_STAT_TWO, 8'h04 << k);
            rd_chk(MON_ADDR_STAT_TWO, 8'h00);
        end
        $display("test fan done");
    endtask

    task automatic t_ovt();
        thermal_alert_pin_exceed = 1'b1;
        tick(2);
        thermal_alert_pin_exceed = 1'b0;
        rd_chk(MON_ADDR_STAT_TWO, 8'h02);
        rd_chk(MON_ADDR_STAT_TWO, 8'h02);
        thermal_alert_pin_recovered = 1'b1;
        rd_chk(MON_ADDR_STAT_TWO, 8'h02);
        rd_chk(MON_ADDR_STAT_TWO, 8'h00);
        thermal_alert_pin_recovered = 1'b0;
        $display("test ovt done");
    endtask

    // twelve volt role: low limit reached on it and on the core rail
    task automatic t_twelve();
        shared_pin_role_select = 1'b0;
        meas.volt[1] = meas.volt_lo[1];
        meas.volt[4] = meas.volt_lo[4];
        tick(2);
        rd_chk(MON_ADDR_STAT_ONE, 8'h82);
        rd_chk(MON_ADDR_STAT_TWO, 8'h01);
        rd_chk(MON_ADDR_STAT_TWO, 8'h01);
        meas.volt[1] = 8'h80;
        meas.volt[4] = 8'h80;
        rd_chk(MON_ADDR_STAT_TWO, 8'h01);
        rd_chk(MON_ADDR_STAT_TWO, 8'h00);
        rd_chk(MON_ADDR_STAT_ONE, 8'h02);
        rd_chk(MON_ADDR_STAT_ONE, 8'h00);
        shared_pin_role_select = 1'b1;
        $display("test twelve done");
    endtask

    // limit 3 ticks of 2 cycles: over after 8 cycles of assertion
    task automatic t_timer();
        timer_pin_mode = 1'b1;
        alert_time_limit = 8'h03;
        thermal_alert_pin = 1'b1;
        tick(20);
        thermal_alert_pin = 1'b0;
        rd_chk(MON_ADDR_STAT_TWO, 8'h20);
        // cause still seen at the clearing read: flag stays one more read
        rd_chk(MON_ADDR_STAT_TWO, 8'h20);
        rd_chk(MON_ADDR_STAT_TWO, 8'h00);
        timer_pin_mode = 1'b0;
        $display("test timer done");
    endtask

    task automatic t_code();
        int w;
        tick(500);
        chk("alert idle", 8'h01, {7'h00, bus_alert_n_ff});
        processor_voltage_code = 6'h2A;
        w = 0;
        while (bus_alert_n_ff !== 1'b0 && w < 1000) begin
            tick(1);
            w++;
        end
        chk("alert", 8'h00, {7'h00, bus_alert_n_ff});
        rd_chk(MON_ADDR_STAT_TWO, 8'h01);
        rd_chk(MON_ADDR_STAT_TWO, 8'h00);
        $display("test code done");
    endtask

    initial begin
        meas.volt = {5{8'h80}};
        meas.volt_lo = {5{8'h10}};
        meas.volt_hi = {5{8'hF0}};
        meas.temp = {3{8'h20}};
        meas.temp_lo = {3{8'hE0}};
        meas.temp_hi = {3{8'h60}};
        meas.fan_tachometer = {4{16'h0800}};
        meas.fan_tachometer_min = {4{16'h1000}};
        thermal_alert_pin_exceed = 1'b0;
        thermal_alert_pin_recovered = 1'b0;
        diode_fault = 2'b00;
        fan_drive_on = 3'b111;
        shared_pin_role_select = 1'b1;
        processor_voltage_code = 6'h15;
        timer_pin_mode = 1'b0;
        thermal_alert_pin = 1'b0;
        alert_time_limit = 8'hFF;
        repeat (3) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_volt();
        t_temp();
        t_diode();
        t_fan();
        t_ovt();
        t_twelve();
        t_timer();
        t_code();
        report_and_stop();
    end
endmodule
`default_nettype wire
